// >>> logic/lin_read_pkg.sv
// Constants and carrier types for the LIN reading-frame handler.
// Assumes a LIN frame layer on the same clock that delivers bytes and frame ends.
package lin_read_pkg;

    // ----------------------------------------
    // Identifiers and fixed bytes
    // ----------------------------------------
    localparam logic [5:0] ID_PREP_LONG   = 6'h3c;
    localparam logic [5:0] ID_READ        = 6'h3d;
    localparam logic [7:0] APP_ESC_BYTE   = 8'h80;
    localparam logic [7:0] FILL_BYTE      = 8'hff;
    localparam logic       ADDR_MARK      = 1'h1;
    localparam logic [3:0] LEN_SHORT      = 4'h2;
    localparam logic [3:0] LEN_MID        = 4'h4;
    localparam logic [3:0] LEN_LONG       = 4'h8;
    localparam logic [3:0] KEPT_BYTES     = 4'h5;

    // ----------------------------------------
    // Application command codes
    // ----------------------------------------
    localparam logic [6:0] CMD_READ_POS    = 7'h00;
    localparam logic [6:0] CMD_READ_FULL   = 7'h01;
    localparam logic [6:0] CMD_READ_FUSE   = 7'h02;
    localparam logic [6:0] CMD_READ_QUICK  = 7'h03;
    localparam logic [6:0] CMD_TO_SAFE     = 7'h04;
    localparam logic [6:0] CMD_HALT_NOW    = 7'h05;
    localparam logic [6:0] CMD_CLEAR_POS   = 7'h06;
    localparam logic [6:0] CMD_RESTORE     = 7'h07;
    localparam logic [6:0] CMD_REF_SEARCH  = 7'h08;
    localparam logic [6:0] CMD_MOTOR_PARAM = 7'h09;
    localparam logic [6:0] CMD_TARGET      = 7'h0b;
    localparam logic [6:0] CMD_SHORT_1     = 7'h0c;
    localparam logic [6:0] CMD_SHORT_2     = 7'h0d;
    localparam logic [6:0] CMD_SHORT_4     = 7'h0e;
    localparam logic [6:0] CMD_RAMP_HALT   = 7'h0f;
    localparam logic [6:0] CMD_FUSE_PROG   = 7'h10;
    localparam logic [6:0] CMD_SLEEP       = 7'h12;

    // ----------------------------------------
    // Action pulses towards the motion core
    // ----------------------------------------
    typedef struct packed {
        logic       halt_now;
        logic       ramp_halt;
        logic       clear_pos;
        logic       restore_defaults;
        logic       ref_search;
        logic       to_safe;
        logic       sleep;
        logic       motor_params;
        logic       write_target;
        logic       fuse_prog;
        logic       short_target;
        logic       half_step_only;
        logic [2:0] short_motors;
    } action_t;

    localparam action_t ACTION_NONE = '0;

endpackage

// >>> logic/resp_store.sv
// Small response buffer with registered read data.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
module resp_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // resp_store

// >>> logic/lin_read_frame_handler.sv
// Slave-side LIN reading-frame handler and application command decoder.
// Assumes a frame layer on REF_CLK delivering received bytes, identifier flags,
// checked frame ends, and taking response bytes with a valid/ready handshake.
`timescale 1ns/1ps
module lin_read_frame_handler
    import lin_read_pkg::*;
#(
    parameter int RESP_DEPTH = 8
) (
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        RX_STB,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_IS_ID,
    input  wire logic        RX_FRAME_END,
    input  wire logic [6:0]  NODE_ADDR,
    input  wire logic [5:0]  DIRECT_POS_ID,
    input  wire logic [5:0]  PREP_SHORT_ID,
    input  wire logic [15:0] CUR_POS,
    input  wire logic [15:0] TARGET_POS,
    input  wire logic [15:0] SAFE_POS,
    input  wire logic [15:0] DEVICE_STATE,
    input  wire logic [63:0] FUSE_CONTENT,
    input  wire logic        TX_READY,
    output logic             TX_VALID,
    output logic      [7:0]  TX_DATA,
    output action_t          ACTIONS,
    output logic      [7:0]  FUSE_ADDR,
    output logic      [7:0]  FUSE_WDATA,
    output logic             FLAGS_ACK,
    output logic             ARMED
);
    // ----------------------------------------
    // Types and state
    // ----------------------------------------
    typedef enum logic [4:0] {
        S_IDLE    = 5'b00001,
        S_COLLECT = 5'b00010,
        S_LOAD    = 5'b00100,
        S_FETCH   = 5'b01000,
        S_HOLD    = 5'b10000
    } state_t;

    state_t      state;
    logic [5:0]  frame_id;
    logic [7:0]  data_b [0:4];
    logic [3:0]  byte_cnt;
    logic [6:0]  armed_cmd;
    logic [6:0]  resp_cmd;
    logic [3:0]  resp_len;
    logic [3:0]  idx;
    logic [7:0]  load_byte;
    logic [7:0]  rd_data;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Length from identifier bits 5:4
    function automatic logic [3:0] len_of_id(input logic [5:0] id);
        case (id[5:4])
            2'b11:   len_of_id = LEN_LONG;
            2'b10:   len_of_id = LEN_MID;
            default: len_of_id = LEN_SHORT;
        endcase
    endfunction

    function automatic logic is_read(input logic [6:0] c);
        is_read = (c == CMD_READ_POS) || (c == CMD_READ_FULL) ||
                  (c == CMD_READ_FUSE) || (c == CMD_READ_QUICK);
    endfunction

    logic       id_seen;
    logic       rx_open;
    logic       direct_hit;
    logic       read_hit;
    logic       long_prep;
    logic       short_prep;
    logic [6:0] fr_cmd;
    logic [6:0] fr_addr;
    logic       addr_hit;
    logic       broadcast;
    logic       frame_done;
    logic       arm_now;
    logic       act_now;

    assign rx_open    = (state == S_IDLE) || (state == S_COLLECT);
    assign id_seen    = rx_open && RX_STB && RX_IS_ID;
    assign direct_hit = RX_DATA[5:0] == DIRECT_POS_ID;
    assign read_hit   = (RX_DATA[5:0] == ID_READ) && ARMED;
    assign frame_done = (state == S_COLLECT) && RX_FRAME_END;
    assign long_prep  = (frame_id == ID_PREP_LONG) && (data_b[0] == APP_ESC_BYTE);
    assign short_prep = (frame_id == PREP_SHORT_ID) && !long_prep;
    assign fr_cmd     = long_prep ? data_b[1][6:0] : data_b[0][6:0];
    assign fr_addr    = long_prep ? data_b[2][6:0] : data_b[1][6:0];
    assign addr_hit   = fr_addr == NODE_ADDR;
    assign broadcast  = long_prep && !data_b[2][7];
    assign arm_now    = frame_done && (long_prep || short_prep) && is_read(fr_cmd) && addr_hit;
    assign act_now    = frame_done && long_prep && !is_read(fr_cmd) && (addr_hit || broadcast);

    // ----------------------------------------
    // Frame sequencing
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state    <= S_IDLE;
            frame_id <= 6'h00;
            byte_cnt <= 4'h0;
            resp_cmd <= CMD_READ_POS;
            resp_len <= 4'h0;
            idx      <= 4'h0;
            TX_VALID <= 1'b0;
            TX_DATA  <= 8'h00;
        end else begin
            case (state)
                S_IDLE, S_COLLECT: begin
                    if (id_seen) begin
                        frame_id <= RX_DATA[5:0];
                        byte_cnt <= 4'h0;
                        idx      <= 4'h0;
                        if (direct_hit) begin
                            resp_cmd <= CMD_READ_POS;
                            resp_len <= len_of_id(RX_DATA[5:0]);
                            state    <= S_LOAD;
                        end else if (read_hit) begin
                            resp_cmd <= armed_cmd;
                            resp_len <= LEN_LONG;
                            state    <= S_LOAD;
                        end else begin
                            state <= S_COLLECT;
                        end
                    end else if (state == S_COLLECT) begin
                        if (RX_FRAME_END) begin
                            state <= S_IDLE;
                        end else if (RX_STB && byte_cnt < KEPT_BYTES) begin
                            byte_cnt <= byte_cnt + 4'h1;
                        end
                    end
                end
                S_LOAD: begin
                    if (idx == resp_len - 4'h1) begin
                        idx   <= 4'h0;
                        state <= S_FETCH;
                    end else begin
                        idx <= idx + 4'h1;
                    end
                end
                S_FETCH: begin
                    state <= S_HOLD;
                end
                S_HOLD: begin
                    if (!TX_VALID) begin
                        TX_VALID <= 1'b1;
                        TX_DATA  <= rd_data;
                    end else if (TX_READY) begin
                        TX_VALID <= 1'b0;
                        if (idx == resp_len - 4'h1) begin
                            state <= S_IDLE;
                        end else begin
                            idx   <= idx + 4'h1;
                            state <= S_FETCH;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Data bytes kept for decoding; fillers beyond are not needed
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < 5; i++) begin
                data_b[i] <= 8'h00;
            end
        end else if (state == S_COLLECT && RX_STB && !RX_IS_ID && byte_cnt < KEPT_BYTES) begin
            data_b[byte_cnt[2:0]] <= RX_DATA;
        end
    end

    // ----------------------------------------
    // Arming for indirect reads
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ARMED     <= 1'b0;
            armed_cmd <= CMD_READ_POS;
        end else begin
            if (id_seen) begin
                ARMED <= 1'b0;
            end
            if (arm_now) begin
                ARMED     <= 1'b1;
                armed_cmd <= fr_cmd;
            end
        end
    end

    // ----------------------------------------
    // Response contents
    // ----------------------------------------
    // Quick status shared with full read
    always_comb begin
        load_byte = FILL_BYTE;
        case (resp_cmd)
            CMD_READ_POS: begin
                case (idx)
                    4'h0:    load_byte = {ADDR_MARK, NODE_ADDR};
                    4'h1:    load_byte = CUR_POS[15:8];
                    4'h2:    load_byte = CUR_POS[7:0];
                    4'h3:    load_byte = DEVICE_STATE[7:0];
                    default: load_byte = FILL_BYTE;
                endcase
            end
            CMD_READ_FULL: begin
                case (idx)
                    4'h0:    load_byte = DEVICE_STATE[15:8];
                    4'h1:    load_byte = DEVICE_STATE[7:0];
                    4'h2:    load_byte = CUR_POS[15:8];
                    4'h3:    load_byte = CUR_POS[7:0];
                    4'h4:    load_byte = TARGET_POS[15:8];
                    4'h5:    load_byte = TARGET_POS[7:0];
                    4'h6:    load_byte = SAFE_POS[15:8];
                    default: load_byte = SAFE_POS[7:0];
                endcase
            end
            CMD_READ_QUICK: begin
                case (idx)
                    4'h0:    load_byte = {ADDR_MARK, NODE_ADDR};
                    4'h1:    load_byte = DEVICE_STATE[7:0];
                    default: load_byte = FILL_BYTE;
                endcase
            end
            CMD_READ_FUSE: begin
                if (idx == 4'h0) begin
                    load_byte = {ADDR_MARK, NODE_ADDR};
                end else begin
                    load_byte = FUSE_CONTENT[8*(idx[2:0]-3'h1) +: 8];
                end
            end
            default: load_byte = FILL_BYTE;
        endcase
    end

    resp_store #(
        .WIDTH (8),
        .DEPTH (RESP_DEPTH),
        .AW    (3)
    ) u_store (
        .clk     (REF_CLK),
        .wr_en   (state == S_LOAD),
        .wr_addr (idx[2:0]),
        .wr_data (load_byte),
        .rd_addr (idx[2:0]),
        .rd_data (rd_data)
    );

    // ----------------------------------------
    // Command execution
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ACTIONS    <= ACTION_NONE;
            FUSE_ADDR  <= 8'h00;
            FUSE_WDATA <= 8'h00;
            FLAGS_ACK  <= 1'b0;
        end else begin
            ACTIONS <= ACTION_NONE;
            FLAGS_ACK <= (state == S_LOAD) && (idx == 4'h0) && (resp_cmd == CMD_READ_FULL);
            if (act_now) begin
                case (fr_cmd)
                    CMD_HALT_NOW:    ACTIONS.halt_now <= 1'b1;
                    CMD_RAMP_HALT:   ACTIONS.ramp_halt <= 1'b1;
                    CMD_CLEAR_POS:   ACTIONS.clear_pos <= 1'b1;
                    CMD_RESTORE:     ACTIONS.restore_defaults <= 1'b1;
                    CMD_REF_SEARCH:  ACTIONS.ref_search <= 1'b1;
                    CMD_TO_SAFE:     ACTIONS.to_safe <= 1'b1;
                    CMD_SLEEP:       ACTIONS.sleep <= 1'b1;
                    CMD_TARGET:      ACTIONS.write_target <= 1'b1;
                    CMD_MOTOR_PARAM: ACTIONS.motor_params <= 1'b1;
                    CMD_FUSE_PROG: begin
                        ACTIONS.fuse_prog <= 1'b1;
                        FUSE_ADDR         <= data_b[3];
                        FUSE_WDATA        <= data_b[4];
                    end
                    CMD_SHORT_1, CMD_SHORT_2, CMD_SHORT_4: begin
                        ACTIONS.short_target   <= 1'b1;
                        ACTIONS.half_step_only <= 1'b1;
                        ACTIONS.short_motors   <= (fr_cmd == CMD_SHORT_1) ? 3'h1 :
                                                  (fr_cmd == CMD_SHORT_2) ? 3'h2 : 3'h4;
                    end
                    default: ACTIONS <= ACTION_NONE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_header(logic hit);
        id_seen && hit;
    endsequence

    property p_arm;
        @(posedge REF_CLK) disable iff (SYS_RST) arm_now |=> ARMED;
    endproperty
    a_arm: assert property (p_arm) else $error("prep frame did not arm");

    property p_cancel;
        @(posedge REF_CLK) disable iff (SYS_RST) id_seen |=> !ARMED;
    endproperty
    a_cancel: assert property (p_cancel) else $error("arm survived a header");

    property p_direct;
        @(posedge REF_CLK) disable iff (SYS_RST)
            s_header(direct_hit) |=> (state == S_LOAD) && (resp_cmd == CMD_READ_POS);
    endproperty
    a_direct: assert property (p_direct) else $error("direct id not answered");

    property p_ind_len;
        @(posedge REF_CLK) disable iff (SYS_RST)
            s_header(read_hit && !direct_hit) |=> resp_len == LEN_LONG;
    endproperty
    a_ind_len: assert property (p_ind_len) else $error("indirect length not 8");

    property p_unarmed;
        @(posedge REF_CLK) disable iff (SYS_RST)
            s_header(!ARMED && !direct_hit) |=> state == S_COLLECT;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("unarmed read answered");

    property p_pos_flags;
        @(posedge REF_CLK) disable iff (SYS_RST)
            (state == S_LOAD) && (resp_cmd == CMD_READ_POS) |=> !FLAGS_ACK;
    endproperty
    a_pos_flags: assert property (p_pos_flags) else $error("position read acked flags");

    property p_clear;
        @(posedge REF_CLK) disable iff (SYS_RST)
            act_now && (fr_cmd == CMD_CLEAR_POS) |=> ACTIONS.clear_pos;
    endproperty
    a_clear: assert property (p_clear) else $error("clear position not issued");

    property p_half;
        @(posedge REF_CLK) disable iff (SYS_RST) ACTIONS.short_target |-> ACTIONS.half_step_only;
    endproperty
    a_half: assert property (p_half) else $error("short move without half step");

    property p_tx_hold;
        @(posedge REF_CLK) disable iff (SYS_RST)
            TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("response byte dropped");

    property p_first_byte;
        @(posedge REF_CLK) disable iff (SYS_RST)
            s_header(direct_hit) ##1 (state == S_LOAD) [*4] ##1 (state == S_FETCH) |-> ##2 TX_VALID;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("response late");

endmodule // lin_read_frame_handler

// >>> testbench/lin_master_model.sv
// LIN master stand-in: sends frame bytes and takes response bytes.
// Assumes the handler's frame-layer ports, all on one clock.
`timescale 1ns/1ps
module lin_master_model (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            rx_stb,
    output logic      [7:0] rx_data,
    output logic            rx_is_id,
    output logic            rx_frame_end,
    output logic            tx_ready
);
    // ----------------------------------------
    // Frame bytes towards the handler
    // ----------------------------------------
    initial begin
        rx_stb       = 1'b0;
        rx_data      = 8'h00;
        rx_is_id     = 1'b0;
        rx_frame_end = 1'b0;
        tx_ready     = 1'b0;
    end
    task automatic send(input logic id, input logic [7:0] b);
        @(posedge clk);
        #1;
        rx_stb   = 1'b1;
        rx_is_id = id;
        rx_data  = b;
        @(posedge clk);
        #1;
        rx_stb   = 1'b0;
        rx_is_id = 1'b0;
        // Idle byte inverted so a stale value cannot pass
        rx_data  = ~b;
    endtask
    task automatic frame_end();
        @(posedge clk);
        #1;
        rx_frame_end = 1'b1;
        @(posedge clk);
        #1;
        rx_frame_end = 1'b0;
    endtask
    // ----------------------------------------
    // Response bytes, random stall before each
    // ----------------------------------------
    task automatic take(output logic [7:0] d, output bit ok);
        int n;
        n = 0;
        while (tx_valid !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (tx_valid === 1'b1);
        d  = 8'h00;
        if (ok) begin
            for (n = $urandom % 3; n > 0; n--) begin
                @(posedge clk);
                #1;
            end
            d        = tx_data;
            tx_ready = 1'b1;
            @(posedge clk);
            #1;
            tx_ready = 1'b0;
        end
    endtask
endmodule // lin_master_model

// >>> testbench/lin_read_frame_handler_bench.sv
// Self-checking bench for the LIN reading-frame handler.
// Assumes lin_master_model on the far side and the design package.
`timescale 1ns/1ps
module lin_read_frame_handler_bench
    import lin_read_pkg::*;
;
    logic        REF_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        RX_STB, RX_IS_ID, RX_FRAME_END, TX_READY, TX_VALID, FLAGS_ACK, ARMED;
    logic [7:0]  RX_DATA, TX_DATA, got, FUSE_ADDR, FUSE_WDATA;
    logic [6:0]  NODE_ADDR = 7'h2b;
    logic [5:0]  DIRECT_POS_ID = 6'h05;
    logic [5:0]  PREP_SHORT_ID = 6'h1a;
    logic [15:0] CUR_POS = 16'h0, TARGET_POS = 16'h0, SAFE_POS = 16'h0, DEVICE_STATE = 16'h0, fx;
    logic [63:0] FUSE_CONTENT = 64'h0, ex;
    action_t     ACTIONS;
    bit          ok;
    int          error_cnt = 0, n_checks = 0, fa_cnt = 0;
    logic [5:0]  dids [3] = '{6'h05, 6'h25, 6'h31};
    int          lens [3] = '{2, 4, 8};
    logic [6:0]  rcmd [4] = '{CMD_READ_POS, CMD_READ_FULL, CMD_READ_QUICK, CMD_READ_FUSE};
    logic [6:0]  acmd [13] = '{CMD_TO_SAFE, CMD_HALT_NOW, CMD_CLEAR_POS, CMD_RESTORE, CMD_REF_SEARCH,
        CMD_MOTOR_PARAM, CMD_TARGET, CMD_SHORT_1, CMD_SHORT_2, CMD_SHORT_4, CMD_RAMP_HALT, CMD_FUSE_PROG, CMD_SLEEP};

    always #2.5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) if (FLAGS_ACK === 1'b1) fa_cnt++;

    lin_read_frame_handler u_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .RX_STB(RX_STB), .RX_DATA(RX_DATA),
        .RX_IS_ID(RX_IS_ID), .RX_FRAME_END(RX_FRAME_END), .NODE_ADDR(NODE_ADDR), .DIRECT_POS_ID(DIRECT_POS_ID),
        .PREP_SHORT_ID(PREP_SHORT_ID), .CUR_POS(CUR_POS), .TARGET_POS(TARGET_POS), .SAFE_POS(SAFE_POS),
        .DEVICE_STATE(DEVICE_STATE), .FUSE_CONTENT(FUSE_CONTENT), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
        .TX_DATA(TX_DATA), .ACTIONS(ACTIONS), .FUSE_ADDR(FUSE_ADDR), .FUSE_WDATA(FUSE_WDATA),
        .FLAGS_ACK(FLAGS_ACK), .ARMED(ARMED));
    lin_master_model u_m (.clk(REF_CLK), .tx_valid(TX_VALID), .tx_data(TX_DATA), .rx_stb(RX_STB),
        .rx_data(RX_DATA), .rx_is_id(RX_IS_ID), .rx_frame_end(RX_FRAME_END), .tx_ready(TX_READY));

    // ----------------------------------------
    // Compare, expectation and report helpers
    // ----------------------------------------
    task automatic note(input string nm, input bit bad, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (bad) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        note(nm, g !== e, {8'h0, e}, {8'h0, g});
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        note(nm, g !== e, {15'h0, e}, {15'h0, g});
    endtask
    task automatic chk_act(input string nm, input action_t e, input action_t g);
        note(nm, g !== e, {1'b0, e}, {1'b0, g});
    endtask
    function automatic logic [63:0] exp_resp(input logic [6:0] cmd);
        logic [63:0] r;
        r = {1'b1, NODE_ADDR, CUR_POS, DEVICE_STATE[7:0], 32'hffff_ffff};
        if (cmd == CMD_READ_FULL) r = {DEVICE_STATE, CUR_POS, TARGET_POS, SAFE_POS};
        if (cmd == CMD_READ_QUICK) r = {1'b1, NODE_ADDR, DEVICE_STATE[7:0], 48'hffff_ffff_ffff};
        if (cmd == CMD_READ_FUSE) for (int k = 0; k < 7; k++) r[55-8*k -: 8] = FUSE_CONTENT[8*k +: 8];
        return r;
    endfunction
    function automatic action_t exp_act(input logic [6:0] cmd);
        action_t a;
        a = ACTION_NONE;
        case (cmd)
            CMD_HALT_NOW:    a.halt_now = 1'b1;
            CMD_RAMP_HALT:   a.ramp_halt = 1'b1;
            CMD_CLEAR_POS:   a.clear_pos = 1'b1;
            CMD_RESTORE:     a.restore_defaults = 1'b1;
            CMD_REF_SEARCH:  a.ref_search = 1'b1;
            CMD_TO_SAFE:     a.to_safe = 1'b1;
            CMD_SLEEP:       a.sleep = 1'b1;
            CMD_MOTOR_PARAM: a.motor_params = 1'b1;
            CMD_TARGET:      a.write_target = 1'b1;
            CMD_FUSE_PROG:   a.fuse_prog = 1'b1;
            default: begin
                a.short_target   = 1'b1;
                a.half_step_only = 1'b1;
                a.short_motors   = 3'h1 << (cmd - CMD_SHORT_1);
            end
        endcase
        return a;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Frame tasks
    // ----------------------------------------
    task automatic no_resp(input int n);
        repeat (n) begin
            @(posedge REF_CLK);
            #1;
            chk_bit("tx_valid_idle", 1'b0, TX_VALID);
        end
    endtask
    task automatic rd(input logic [5:0] id, input int len, input logic [6:0] cmd);
        ex = exp_resp(cmd);
        u_m.send(1'b1, {2'($urandom), id});
        for (int i = 0; i < len; i++) begin
            u_m.take(got, ok);
            chk_bit("resp_present", 1'b1, ok);
            chk_byte("resp_byte", ex[63-8*i -: 8], got);
        end
        no_resp(12);
    endtask
    // Returns right after the frame-end edge: action pulses last one cycle
    task automatic prep(input bit lng, input logic [6:0] cmd, input logic [7:0] adr, input logic [15:0] prm);
        u_m.send(1'b1, {2'($urandom), lng ? ID_PREP_LONG : PREP_SHORT_ID});
        if (lng) u_m.send(1'b0, APP_ESC_BYTE);
        u_m.send(1'b0, {1'b1, cmd});
        u_m.send(1'b0, adr);
        if (lng) begin
            u_m.send(1'b0, prm[15:8]);
            u_m.send(1'b0, prm[7:0]);
            repeat (3) u_m.send(1'b0, FILL_BYTE);
        end
        u_m.frame_end();
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        void'($urandom(32'h7a7d8112));
        repeat (4) @(posedge REF_CLK);
        #1;
        SYS_RST = 1'b0;
        foreach (dids[k]) begin
            DIRECT_POS_ID = dids[k];
            CUR_POS = 16'($urandom);
            DEVICE_STATE = 16'($urandom);
            rd(dids[k], lens[k], CMD_READ_POS);
        end
        chk_byte("flag_acks", 8'h0, 8'(fa_cnt));
        for (int p = 0; p < 8; p++) begin
            {CUR_POS, TARGET_POS, SAFE_POS, DEVICE_STATE} = {$urandom, $urandom};
            FUSE_CONTENT = {$urandom, $urandom};
            prep(p[0], rcmd[p>>1], {1'b1, NODE_ADDR}, 16'hffff);
            chk_bit("armed", 1'b1, ARMED);
            rd(ID_READ, 8, rcmd[p>>1]);
        end
        chk_byte("flag_acks", 8'h2, 8'(fa_cnt));
        prep(1'b1, CMD_READ_POS, {1'b1, NODE_ADDR}, 16'hffff);
        u_m.send(1'b1, 8'h22);
        u_m.frame_end();
        chk_bit("armed", 1'b0, ARMED);
        u_m.send(1'b1, {2'b01, ID_READ});
        no_resp(20);
        prep(1'b0, CMD_READ_POS, {1'b1, NODE_ADDR ^ 7'h01}, 16'hffff);
        chk_bit("armed", 1'b0, ARMED);
        u_m.send(1'b1, {2'b01, ID_READ});
        no_resp(20);
        foreach (acmd[k]) begin
            fx = 16'($urandom);
            prep(1'b1, acmd[k], {k[0], NODE_ADDR}, fx);
            chk_act("actions", exp_act(acmd[k]), ACTIONS);
            chk_bit("armed", 1'b0, ARMED);
            if (acmd[k] == CMD_FUSE_PROG) begin
                chk_byte("fuse_addr", fx[15:8], FUSE_ADDR);
                chk_byte("fuse_wdata", fx[7:0], FUSE_WDATA);
            end
            @(posedge REF_CLK);
            #1;
            chk_act("actions_end", ACTION_NONE, ACTIONS);
        end
        prep(1'b1, CMD_HALT_NOW, {1'b1, NODE_ADDR ^ 7'h7f}, 16'hffff);
        chk_act("actions_other", ACTION_NONE, ACTIONS);
        summarize();
    end
    initial begin
        #(60000 * 5);
        error_cnt++;
        summarize();
    end
endmodule // lin_read_frame_handler_bench
